// ===== inc/pslv_consts.vh
// Constants for the parallel slave port block
`ifndef PSLV_CONSTS_VH
`define PSLV_CONSTS_VH

// =============================================
// Data path
`define PSLV_DATA_W 8
`define PSLV_FIFO_DEPTH 8
`define PSLV_FIFO_AW 3
`define PSLV_SYNC_STAGES 3

// =============================================
// Quarter phases of the instruction cycle
`define PSLV_PHASE_Q1 2'h0
`define PSLV_PHASE_Q2 2'h1
`define PSLV_PHASE_Q3 2'h2
`define PSLV_PHASE_Q4 2'h3

// =============================================
// Bus cycle states
`define PSLV_BUS_IDLE 2'h0
`define PSLV_BUS_WRITE 2'h1
`define PSLV_BUS_READ 2'h2

// =============================================
// Completion timer states
`define PSLV_DONE_IDLE 2'h0
`define PSLV_DONE_WAIT_Q2 2'h1
`define PSLV_DONE_WAIT_Q4 2'h2

// =============================================
// Reset values
`define PSLV_RST_BYTE 8'h00
`define PSLV_RST_PHASE 2'h0
`define PSLV_RST_SYNC 3'h7

`endif

// ===== hw/pslv_fifo.v
// Parameterised valid/ready FIFO for firmware bytes bound for the output latch
`timescale 1ns/1ns
module pslv_fifo
#(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
)
(
    input wire sys_clk,
    input wire reset_n,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_ptr;
reg [AW-1:0] rd_ptr;
reg [AW:0] count;
wire push;
wire pop;

assign in_ready = (count != DEPTH[AW:0]);
assign out_valid = (count != {(AW+1){1'b0}});
assign out_data = mem[rd_ptr];
assign push = in_valid && in_ready;
assign pop = out_valid && out_ready;

// =============================================
// Storage
always @(posedge sys_clk)
begin
    if (push)
    begin
        mem[wr_ptr] <= in_data;
    end
end

// =============================================
// Pointers and fill level
always @(posedge sys_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        wr_ptr <= {AW{1'b0}};
        rd_ptr <= {AW{1'b0}};
        count <= {(AW+1){1'b0}};
    end
    else
    begin
        if (push)
        begin
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
        end
        if (pop)
        begin
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
        end
        if (push && !pop)
        begin
            count <= count + 1'b1;
        end
        else if (pop && !push)
        begin
            count <= count - 1'b1;
        end
    end
end

endmodule

// ===== hw/pslv_port.v
// Parallel slave port: external processor bus to firmware latches and flags
// Functional notes
// - Mode bit turns data port into slave port
// - External side needs no clock of its own
// - Mode bit makes three pins strobes, select
// - Separate input and output latches, one address
// - Port D direction ignored; strobes steer data
// - Select and write low start capture
// - Write end sets input full at Q4
// - Same Q4 also sets port interrupt flag
// - Firmware read or mode off clears input full
// - Write while input full sets overflow
// - Select and read low clear output full
// - Read end sets interrupt flag at Q4
// - Output full stays low until the read ends and the FIFO holds a byte
// - Mode off clears full flags, keeps overflow
// - Interrupt flag latched; request gated by enable
`timescale 1ns/1ns
`include "pslv_consts.vh"
module pslv_port
(
    input wire sys_clk,
    input wire reset_n,
    input wire slave_mode_enable_bit,
    input wire [7:0] port_d_direction_reg,
    input wire read_strobe_pin_n,
    input wire write_strobe_pin_n,
    input wire select_pin_n,
    input wire [7:0] data_pin_in,
    output reg [7:0] data_pin_out,
    output reg data_pin_oe,
    input wire fw_write_valid,
    output reg fw_write_ready,
    input wire [7:0] fw_write_data,
    input wire fw_read,
    output reg [7:0] fw_read_data,
    output reg input_full_flag,
    output reg output_full_flag,
    output reg input_overflow_flag,
    input wire fw_overflow_clear,
    output reg port_irq_flag,
    input wire fw_irq_clear,
    input wire port_irq_enable,
    output reg irq_request
);

// =============================================
// Declarations
reg [1:0] phase;
reg [2:0] strobe_s1;
reg [2:0] strobe_s2;
reg [2:0] strobe_s3;
reg [2:0] strobe_level;
reg [7:0] data_s1;
reg [7:0] data_s2;
reg [7:0] data_s3;
reg [7:0] data_s4;
reg [1:0] bus_state;
reg [1:0] next_bus_state;
reg [1:0] done_state;
reg [1:0] next_done_state;
reg done_is_write;
reg [7:0] output_latch;
wire [2:0] strobe_raw;
wire rd_low;
wire wr_low;
wire cs_low;
wire write_start;
wire write_end;
wire read_start;
wire read_end;
wire done_fire;
wire fifo_in_ready;
wire fifo_out_valid;
wire fifo_out_ready;
wire [7:0] fifo_out_data;
wire latch_load;

// Pin order inside the strobe vectors: read, write, select
assign strobe_raw = {select_pin_n, write_strobe_pin_n, read_strobe_pin_n};

// Active-low decode of one filtered strobe level
function pslv_low;
    input [2:0] lv;
    input integer idx;
    begin
        pslv_low = ~lv[idx];
    end
endfunction

assign rd_low = pslv_low(strobe_level, 0);
assign wr_low = pslv_low(strobe_level, 1);
assign cs_low = pslv_low(strobe_level, 2);

// =============================================
// Quarter-phase generator
// One sys_clk edge per phase; four edges form one instruction cycle
always @(posedge sys_clk or negedge reset_n)
begin
    if (!reset_n)
        phase <= `PSLV_RST_PHASE;
    else
        phase <= phase + 2'h1;
end

// =============================================
// Strobe synchronisers
// Asynchronous pins, no external clock; first stage feeds only the second
genvar gi;
generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_sync
        always @(posedge sys_clk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                strobe_s1[gi] <= 1'b1;
                strobe_s2[gi] <= 1'b1;
                strobe_s3[gi] <= 1'b1;
                strobe_level[gi] <= 1'b1;
            end
            else
            begin
                strobe_s1[gi] <= strobe_raw[gi];
                strobe_s2[gi] <= strobe_s1[gi];
                strobe_s3[gi] <= strobe_s2[gi];
                if (strobe_s2[gi] == strobe_s3[gi])
                begin
                    strobe_level[gi] <= strobe_s3[gi];
                end
            end
        end
    end
endgenerate

// =============================================
// Data pin synchroniser
// Last stage matches the strobe agreement delay, so a byte lines up with its strobes
always @(posedge sys_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        data_s1 <= `PSLV_RST_BYTE;
        data_s2 <= `PSLV_RST_BYTE;
        data_s3 <= `PSLV_RST_BYTE;
        data_s4 <= `PSLV_RST_BYTE;
    end
    else
    begin
        data_s1 <= data_pin_in;
        data_s2 <= data_s1;
        data_s3 <= data_s2;
        data_s4 <= data_s3;
    end
end

// =============================================
// External bus cycle tracking
assign write_start = slave_mode_enable_bit && (bus_state == `PSLV_BUS_IDLE)
    && cs_low && wr_low;
assign read_start = slave_mode_enable_bit && (bus_state == `PSLV_BUS_IDLE)
    && cs_low && rd_low && !wr_low;
assign write_end = (bus_state == `PSLV_BUS_WRITE) && !(cs_low && wr_low);
assign read_end = (bus_state == `PSLV_BUS_READ) && !(cs_low && rd_low);

always @*
begin
    next_bus_state = bus_state;
    case (bus_state)
        `PSLV_BUS_IDLE:
            if (write_start)
                next_bus_state = `PSLV_BUS_WRITE;
            else if (read_start)
                next_bus_state = `PSLV_BUS_READ;
        `PSLV_BUS_WRITE:
            if (write_end || !slave_mode_enable_bit)
                next_bus_state = `PSLV_BUS_IDLE;
        `PSLV_BUS_READ:
            if (read_end || !slave_mode_enable_bit)
                next_bus_state = `PSLV_BUS_IDLE;
        default:
            next_bus_state = `PSLV_BUS_IDLE;
    endcase
end

always @(posedge sys_clk or negedge reset_n)
begin
    if (!reset_n)
        bus_state <= `PSLV_BUS_IDLE;
    else
        bus_state <= next_bus_state;
end

// =============================================
// Completion timer: Q4 that follows the next Q2
// A new cycle may start while this runs; a second end before Q4 merges
assign done_fire = (done_state == `PSLV_DONE_WAIT_Q4) && (phase == `PSLV_PHASE_Q4);

always @*
begin
    next_done_state = done_state;
    case (done_state)
        `PSLV_DONE_IDLE:
            if ((write_end || read_end) && slave_mode_enable_bit)
                next_done_state = `PSLV_DONE_WAIT_Q2;
        `PSLV_DONE_WAIT_Q2:
            if (phase == `PSLV_PHASE_Q2)
                next_done_state = `PSLV_DONE_WAIT_Q4;
        `PSLV_DONE_WAIT_Q4:
            if (phase == `PSLV_PHASE_Q4)
                next_done_state = `PSLV_DONE_IDLE;
        default:
            next_done_state = `PSLV_DONE_IDLE;
    endcase
end

always @(posedge sys_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        done_state <= `PSLV_DONE_IDLE;
        done_is_write <= 1'b0;
    end
    else
    begin
        done_state <= next_done_state;
        if (done_state == `PSLV_DONE_IDLE && (write_end || read_end))
            done_is_write <= write_end;
    end
end

// =============================================
// Input latch and its flags
// On overflow the unread byte is kept; the new byte is dropped
always @(posedge sys_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        fw_read_data <= `PSLV_RST_BYTE;
        input_full_flag <= 1'b0;
        input_overflow_flag <= 1'b0;
    end
    else
    begin
        if (bus_state == `PSLV_BUS_WRITE && !write_end && !input_full_flag)
            fw_read_data <= data_s4;
        else if (write_start && !input_full_flag)
            fw_read_data <= data_s4;
        if (!slave_mode_enable_bit)
            input_full_flag <= 1'b0;
        else if (done_fire && done_is_write)
            input_full_flag <= 1'b1;
        else if (fw_read)
            input_full_flag <= 1'b0;
        if (write_start && input_full_flag)
            input_overflow_flag <= 1'b1;
        else if (fw_overflow_clear)
            input_overflow_flag <= 1'b0;
    end
end

// =============================================
// Output latch fed from the firmware FIFO
// Latch reloads only when empty and no read is under way, so a read never sees it change
assign latch_load = fifo_out_valid && fifo_out_ready;
assign fifo_out_ready = (!output_full_flag || !slave_mode_enable_bit)
    && (bus_state != `PSLV_BUS_READ) && !read_start;

pslv_fifo
#(
    .WIDTH(`PSLV_DATA_W),
    .DEPTH(`PSLV_FIFO_DEPTH),
    .AW(`PSLV_FIFO_AW)
)
u_out_fifo
(
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .in_valid(fw_write_valid),
    .in_ready(fifo_in_ready),
    .in_data(fw_write_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
);

always @(posedge sys_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        output_latch <= `PSLV_RST_BYTE;
        output_full_flag <= 1'b0;
        fw_write_ready <= 1'b0;
    end
    else
    begin
        fw_write_ready <= fifo_in_ready;
        if (latch_load)
        begin
            output_latch <= fifo_out_data;
        end
        if (!slave_mode_enable_bit)
        begin
            output_full_flag <= 1'b0;
        end
        else if (read_start)
        begin
            output_full_flag <= 1'b0;
        end
        else if (latch_load)
        begin
            output_full_flag <= 1'b1;
        end
    end
end

// =============================================
// Data pin drive
// Port D direction plays no part while the slave port owns the pins
always @(posedge sys_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        data_pin_out <= `PSLV_RST_BYTE;
        data_pin_oe <= 1'b0;
    end
    else
    begin
        data_pin_out <= output_latch;
        if (slave_mode_enable_bit)
        begin
            data_pin_oe <= cs_low && rd_low && !wr_low;
        end
        else
        begin
            data_pin_oe <= (port_d_direction_reg == 8'h00);
        end
    end
end

// =============================================
// Interrupt flag and request
always @(posedge sys_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        port_irq_flag <= 1'b0;
        irq_request <= 1'b0;
    end
    else
    begin
        if (done_fire)
            port_irq_flag <= 1'b1;
        else if (fw_irq_clear)
            port_irq_flag <= 1'b0;
        irq_request <= (port_irq_flag || done_fire) && port_irq_enable;
    end
end

endmodule

// ===== sim/pslv_port_properties.sv
// Assertion checker for the parallel slave port
`timescale 1ns/1ns
module pslv_port_props
(
    input wire sys_clk,
    input wire reset_n,
    input wire slave_mode_enable_bit,
    input wire read_strobe_pin_n,
    input wire write_strobe_pin_n,
    input wire select_pin_n,
    input wire data_pin_oe,
    input wire fw_read,
    input wire input_full_flag,
    input wire output_full_flag,
    input wire input_overflow_flag,
    input wire fw_overflow_clear,
    input wire port_irq_flag,
    input wire fw_irq_clear,
    input wire port_irq_enable,
    input wire irq_request
);
    // ==========================================
    // Properties
    wire on = slave_mode_enable_bit;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    property p_off; !on |=> !input_full_flag && !output_full_flag; endproperty
    a_off: assert property (p_off) else $error("full flag outside mode");
    property p_req; port_irq_flag && port_irq_enable |=> irq_request; endproperty
    a_req: assert property (p_req) else $error("request missing");
    property p_ovf; input_overflow_flag && !fw_overflow_clear |=> input_overflow_flag; endproperty
    a_ovf: assert property (p_ovf) else $error("overflow lost");
    property p_irq; port_irq_flag && !fw_irq_clear |=> port_irq_flag; endproperty
    a_irq: assert property (p_irq) else $error("irq flag lost");
    property p_full; input_full_flag && on && !fw_read |=> input_full_flag; endproperty
    a_full: assert property (p_full) else $error("input full lost");
    property p_fi; $rose(input_full_flag) |-> port_irq_flag; endproperty
    a_fi: assert property (p_fi) else $error("irq not with full");
    // Eight idle cycles cover the strobe filter delay
    property p_oe; (on && (select_pin_n || read_strobe_pin_n))[*8] |-> !data_pin_oe; endproperty
    a_oe: assert property (p_oe) else $error("pins driven while idle");
    property p_rd; $fell(output_full_flag) && on && $past(on) |=> data_pin_oe; endproperty
    a_rd: assert property (p_rd) else $error("read start without drive");
    property p_done; $rose(select_pin_n) && on |-> ##[5:16] port_irq_flag; endproperty
    a_done: assert property (p_done) else $error("completion late");
    c_wr: cover property ($rose(input_full_flag));
    c_ov: cover property ($rose(input_overflow_flag));
    c_rd: cover property ($rose(data_pin_oe) && on);
endmodule

bind pslv_port pslv_port_props u_props
(
    .sys_clk(sys_clk), .reset_n(reset_n), .slave_mode_enable_bit(slave_mode_enable_bit),
    .read_strobe_pin_n(read_strobe_pin_n), .write_strobe_pin_n(write_strobe_pin_n),
    .select_pin_n(select_pin_n), .data_pin_oe(data_pin_oe), .fw_read(fw_read),
    .input_full_flag(input_full_flag), .output_full_flag(output_full_flag),
    .input_overflow_flag(input_overflow_flag), .fw_overflow_clear(fw_overflow_clear),
    .port_irq_flag(port_irq_flag), .fw_irq_clear(fw_irq_clear),
    .port_irq_enable(port_irq_enable), .irq_request(irq_request)
);

// ===== sim/pslv_host_model.sv
// External processor bus master model
`timescale 1ns/1ns
module pslv_host_model
(
    input wire sys_clk,
    input wire [7:0] dev_data,
    input wire dev_oe,
    output logic select_pin_n = 1'b1,
    output logic read_strobe_pin_n = 1'b1,
    output logic write_strobe_pin_n = 1'b1,
    output wire [7:0] bus_data
);
    // No pull-ups: a released bus shows the inverse of its last byte
    logic [7:0] drv = 8'h00;
    assign bus_data = dev_oe ? dev_data : drv;
    task automatic xfer(input logic wr, input logic [7:0] d, input int len,
        output logic [7:0] q);
        @(posedge sys_clk);
        #1;
        select_pin_n = 1'b0;
        write_strobe_pin_n = !wr;
        read_strobe_pin_n = wr;
        if (wr)
            drv = d;
        repeat (len) @(posedge sys_clk);
        q = bus_data;
        #1;
        select_pin_n = 1'b1;
        write_strobe_pin_n = 1'b1;
        read_strobe_pin_n = 1'b1;
        drv = ~q;
        repeat (16) @(posedge sys_clk);
        #1;
    endtask
endmodule

// ===== sim/test_parallel_slave_port.sv
// Self-checking bench for the parallel slave port
`timescale 1ns/1ns
module test_parallel_slave_port;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic slv = 1'b0;
    logic [7:0] dir = 8'hFF;
    logic w_valid = 1'b0;
    logic [7:0] w_data = 8'h00;
    logic rd_p = 1'b0;
    logic ov_clr = 1'b0;
    logic irq_clr = 1'b0;
    logic irq_en = 1'b1;
    wire cs_n, rd_n, wr_n, oe, w_ready, in_full, out_full, ovf, irq_flag, irq_req;
    wire [7:0] dout, din, rdata;
    logic [16:0] seed = 17'h12AF3;
    logic [7:0] q, m, lat;
    logic [7:0] fq[$];
    int bad_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int n;
    pslv_port dut (.sys_clk(sys_clk), .reset_n(reset_n), .slave_mode_enable_bit(slv),
        .port_d_direction_reg(dir), .read_strobe_pin_n(rd_n), .write_strobe_pin_n(wr_n),
        .select_pin_n(cs_n), .data_pin_in(din), .data_pin_out(dout), .data_pin_oe(oe),
        .fw_write_valid(w_valid), .fw_write_ready(w_ready), .fw_write_data(w_data),
        .fw_read(rd_p), .fw_read_data(rdata), .input_full_flag(in_full),
        .output_full_flag(out_full), .input_overflow_flag(ovf), .fw_overflow_clear(ov_clr),
        .port_irq_flag(irq_flag), .fw_irq_clear(irq_clr), .port_irq_enable(irq_en),
        .irq_request(irq_req));
    pslv_host_model host (.sys_clk(sys_clk), .dev_data(dout), .dev_oe(oe),
        .select_pin_n(cs_n), .read_strobe_pin_n(rd_n), .write_strobe_pin_n(wr_n),
        .bus_data(din));
    // ==========================================
    // Helpers
    initial
    begin
        forever #4 sys_clk = ~sys_clk;
    end
    function logic [7:0] rnd();
        seed = {seed[15:0], seed[16] ^ seed[13]};
        return seed[7:0];
    endfunction
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    task fw(input int k);
        @(posedge sys_clk);
        #1;
        rd_p = (k == 0);
        ov_clr = (k == 1);
        irq_clr = (k == 2);
        @(posedge sys_clk);
        #1;
        {rd_p, ov_clr, irq_clr} = 3'h0;
        @(posedge sys_clk);
        #1;
    endtask
    task hw(input logic [7:0] d);
        host.xfer(1'b1, d, 8 + rnd() % 8, q);
    endtask
    task push(input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        w_valid = 1'b1;
        w_data = d;
        @(posedge sys_clk);
        #1;
        w_valid = 1'b0;
    endtask
    task close_out();
        $display("Counts: %0d checks, %0d mismatches", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Ceiling well above the roughly 500 cycles of traffic
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            bad_count++;
            close_out();
        end
    end
    // ==========================================
    // Scenarios
    initial
    begin
        repeat (8) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 chk("flags", 8'h00, {in_full, out_full, ovf, irq_flag, irq_req});
        slv = 1'b1;
        dir = 8'h00;
        lat = rnd();
        hw(lat);
        chk("latch", lat, rdata);
        chk("write", 8'h07, {in_full, irq_flag, irq_req});
        chk("drive", 8'h00, oe);
        hw(~lat);
        chk("kept", lat, rdata);
        chk("ovf", 8'h03, {in_full, ovf});
        fw(0);
        chk("read", 8'h01, {in_full, ovf});
        fw(1);
        fw(2);
        irq_en = 1'b0;
        hw(rnd());
        chk("mask", 8'h02, {irq_flag, irq_req});
        irq_en = 1'b1;
        @(posedge sys_clk);
        #1 chk("unmask", 8'h01, irq_req);
        fw(0);
        fw(2);
        $display("write tests done");
        n = 0;
        // Ready is registered: look one edge after each push, not at once
        @(posedge sys_clk);
        #1;
        while (w_ready === 1'b1 && n < 12)
        begin
            m = rnd();
            fq.push_back(m);
            push(m);
            n++;
            @(posedge sys_clk);
            #1;
        end
        chk("accepted", 8'h09, n[7:0]);
        repeat (9)
        begin
            chk("queued", 8'h01, out_full);
            host.xfer(1'b0, 8'h00, 8 + rnd() % 8, q);
            chk("read data", fq.pop_front(), q);
            chk("done", 8'h01, irq_flag);
            fw(2);
        end
        chk("empty", 8'h00, out_full);
        $display("read tests done");
        hw(rnd());
        hw(rnd());
        push(rnd());
        @(posedge sys_clk);
        #1 slv = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 chk("mode off", 8'h01, {in_full, out_full, ovf});
        fw(2);
        hw(rnd());
        chk("ignored", 8'h00, {in_full, irq_flag});
        $display("mode tests done");
        close_out();
    end
endmodule
